// *** hdl/dks_cfg.svh ***
// Constants for the digitizer keypad sequencer: key codes, letters, reset values, timing.
// Assumes inclusion by the timer and sequencer design files; definitions only.
`ifndef DKS_CFG_SVH
`define DKS_CFG_SVH

// Key codes on the 4-bit keypad bus (digits 0-9 are their own value)
`define DKS_KEY_SHIFT   4'h7
`define DKS_KEY_AX1     4'ha
`define DKS_KEY_AX2     4'hb
`define DKS_KEY_ARCA    4'hc
`define DKS_KEY_ARCB    4'hd
`define DKS_KEY_FNP     4'he
`define DKS_KEY_MINUS   4'hf
`define DKS_DIGIT_MAX   4'h9

// Measuring-system letters, ASCII
`define DKS_LET_INCH    8'h45
`define DKS_LET_FEET    8'h41
`define DKS_LET_METRIC  8'h43

// Reset values
`define DKS_POS_RST     32'sh0000_0000
`define DKS_SCALE_ONE   32'sh0000_0001

// LED dot patterns, bit 3 = A .. bit 0 = D
`define DKS_LED_PRESET  4'h9
`define DKS_LED_SCALE   4'hc
`define DKS_LED_MINUS   4'h3
`define DKS_LED_ALL     4'hf
`define DKS_LED_SHIFT   4'h1
`define DKS_LED_IDLE    4'h1
`define DKS_LED_OFF     4'h0

// Timing: LED flash lengths in ns and derived cycles at 4 ns per clock
`define DKS_CLK_NS      4
`define DKS_FLASH_NS    2000
`define DKS_FLASH_CYC   (`DKS_FLASH_NS / `DKS_CLK_NS)
`define DKS_BLINK_NS    1000
`define DKS_BLINK_CYC   (`DKS_BLINK_NS / `DKS_CLK_NS)

`endif

// *** hdl/dks_led_timer.sv ***
// LED flash timer: holds a pattern for a cycle count after a trigger.
// Assumes a synchronous active-low reset and one clock.
`timescale 1ns/10ps
`include "dks_cfg.svh"

module dks_led_timer
    import dks_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             nrst_i,
    // Trigger
    input  wire logic             start_i,
    input  wire logic [CNT_W-1:0] len_i,
    input  wire logic [3:0]       pat_i,
    // Result
    output logic                  busy_o,
    output logic [3:0]            pat_o
);

    logic [CNT_W-1:0] cnt_r;   // Remaining cycles
    logic [3:0]       pat_r;   // Held pattern

    // Countdown, reloaded by a trigger
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cnt_r <= '0;
        end else if (start_i) begin
            cnt_r <= len_i;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Pattern capture
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            pat_r <= `DKS_LED_OFF;
        end else if (start_i) begin
            pat_r <= pat_i;
        end
    end

    assign busy_o = (cnt_r != '0);
    assign pat_o  = pat_r;

    // A trigger loads its length and pattern for the next cycle
    property p_load;
        @(posedge mclk_i) disable iff (!nrst_i)
        start_i |=> (cnt_r == $past(len_i)) && (pat_o == $past(pat_i));
    endproperty
    a_load: assert property (p_load) else $error("flash not loaded");

    // A running flash counts down by one each cycle
    property p_count;
        @(posedge mclk_i) disable iff (!nrst_i)
        (busy_o && !start_i) |=> cnt_r == $past(cnt_r) - 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("flash count skipped");

endmodule : dks_led_timer

// *** hdl/dks_pkg.sv ***
// Types shared by the digitizer keypad sequencer.
// Assumes the cfg header carries all numeric constants.
package dks_pkg;

    // Entry sequencer states
    typedef enum logic [2:0] {
        DKS_IDLE    = 3'b000,
        DKS_SHIFTED = 3'b001,
        DKS_PRESET  = 3'b010,
        DKS_SCALE   = 3'b011,
        DKS_DIAM    = 3'b100
    } dks_state_t;

    // Record marker sent with coordinates
    typedef enum logic [2:0] {
        DKS_REC_PENUP   = 3'b000,
        DKS_REC_PENDOWN = 3'b001,
        DKS_REC_ARCPT   = 3'b010,
        DKS_REC_ARCBLK  = 3'b011,
        DKS_REC_EOF     = 3'b100
    } dks_rec_t;

    // Output record
    typedef struct packed {
        dks_rec_t    kind;
        logic [31:0] x;
        logic [31:0] y;
        logic        diam;
    } dks_record_t;

endpackage : dks_pkg

// *** hdl/dks_sequencer.sv ***
// Keypad command sequencer for a coordinate digitizer.
// Assumes key codes arrive as one-cycle strobes synchronous to mclk_i.
// What this block does
// - Shift key is 7 unless function follows
// - Plain X key sends coordinates, pen up
// - Shift X, number, X presets X axis
// - Shift X X without digits cancels
// - Y key like X, but pen down
// - Plain A sends first arc point
// - Shift A, number, A sets X scale
// - Plain B sends arc end block
// - Shift B, number, B sets Y scale
// - Display frozen during any entry
// - Minus before number marks diameter
// - Shift then minus sends end of file
// - Minus inside preset/scale negates value
// - Units letter E, A or C
// - Two LEDs only while entry incomplete or after reset
// - A+D for preset, A+B for scale
// - A+B cleared by closing key
// - C+D after reset or minus
// - All LEDs on lockout, flash at reset
// - D after shift, pulse on shift P
// - X on upper row, Y on lower
// - Reset zeroes display, scale one; units follow units_sel_i
`timescale 1ns/10ps
`include "dks_cfg.svh"

module dks_sequencer
    import dks_pkg::*;
#(
    parameter int FLASH_CYC = `DKS_FLASH_CYC,
    parameter int BLINK_CYC = `DKS_BLINK_CYC
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // Keypad
    input  wire logic        key_vld_i,
    input  wire logic [3:0]  key_code_i,
    input  wire logic        lockout_i,
    input  wire logic [1:0]  units_sel_i,
    // Carriage position
    input  wire logic [31:0] pos_x_i,
    input  wire logic [31:0] pos_y_i,
    // Record output
    output logic             rec_vld_o,
    output dks_record_t      rec_o,
    // Display and indicators
    output logic [31:0]      disp_top_o,
    output logic [31:0]      disp_bot_o,
    output logic [31:0]      scale_x_o,
    output logic [31:0]      scale_y_o,
    output logic [7:0]       units_let_o,
    output logic [3:0]       led_o,
    output logic             frozen_o
);

    dks_state_t  state_r, state_nxt;  // Entry state
    logic        tgt_r;               // Entry target: 0 = first axis key, 1 = second
    logic        neg_r;               // Negative sign pending
    logic        digs_r;              // At least one digit entered
    logic [31:0] acc_r;               // Value being entered
    logic [31:0] off_x_r, off_y_r;    // Preset offsets
    logic [31:0] sc_x_r,  sc_y_r;     // Scale factors
    logic [31:0] frz_x_r, frz_y_r;    // Frozen display
    logic        minus_r;             // Minus just pressed
    logic        rst_seen_r;          // Reset not yet followed by a key
    logic [31:0] live_x, live_y;      // Scaled live coordinates
    logic        is_digit;            // Key is a digit
    logic        fl_start;            // Start LED flash
    logic        fl_busy;             // Flash active
    logic [3:0]  fl_pat;              // Flash pattern
    logic [15:0] fl_len;              // Flash length
    logic [3:0]  fl_pat_q;            // Pattern held by the timer

    assign is_digit = key_vld_i && (key_code_i <= `DKS_DIGIT_MAX);

    // Live coordinate in units and scale
    assign live_x = (pos_x_i + off_x_r) * sc_x_r;
    assign live_y = (pos_y_i + off_y_r) * sc_y_r;

    // Next-state for the entry sequencer
    always_comb begin
        state_nxt = state_r;
        if (key_vld_i && !lockout_i) begin
            case (state_r)
                DKS_IDLE: begin
                    if (key_code_i == `DKS_KEY_SHIFT) begin
                        state_nxt = DKS_SHIFTED;
                    end else if (key_code_i == `DKS_KEY_MINUS) begin
                        state_nxt = DKS_DIAM;
                    end
                end
                DKS_SHIFTED: begin
                    if (key_code_i == `DKS_KEY_AX1 || key_code_i == `DKS_KEY_AX2) begin
                        state_nxt = DKS_PRESET;
                    end else if (key_code_i == `DKS_KEY_ARCA
                                 || key_code_i == `DKS_KEY_ARCB) begin
                        state_nxt = DKS_SCALE;
                    end else begin
                        state_nxt = DKS_IDLE;
                    end
                end
                DKS_PRESET, DKS_SCALE: begin
                    if ((key_code_i == `DKS_KEY_AX1 && !tgt_r && state_r == DKS_PRESET)
                        || (key_code_i == `DKS_KEY_AX2 && tgt_r && state_r == DKS_PRESET)
                        || (key_code_i == `DKS_KEY_ARCA && !tgt_r && state_r == DKS_SCALE)
                        || (key_code_i == `DKS_KEY_ARCB && tgt_r && state_r == DKS_SCALE)) begin
                        state_nxt = DKS_IDLE;
                    end
                end
                DKS_DIAM: begin
                    if (!is_digit && key_code_i != `DKS_KEY_SHIFT) begin
                        state_nxt = DKS_IDLE;
                    end
                end
                default: state_nxt = DKS_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            state_r <= DKS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Entry target, sign, digits, accumulator
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            tgt_r  <= 1'b0;
            neg_r  <= 1'b0;
            digs_r <= 1'b0;
            acc_r  <= '0;
        end else if (key_vld_i && !lockout_i) begin
            if (state_r == DKS_SHIFTED) begin
                tgt_r  <= (key_code_i == `DKS_KEY_AX2 || key_code_i == `DKS_KEY_ARCB);
                neg_r  <= 1'b0;
                digs_r <= 1'b0;
                acc_r  <= '0;
            end else if (state_r == DKS_IDLE && key_code_i == `DKS_KEY_MINUS) begin
                digs_r <= 1'b0;
                acc_r  <= '0;
            end else if (state_r != DKS_IDLE && is_digit) begin
                digs_r <= 1'b1;
                acc_r  <= 32'((acc_r * 10) + 32'(key_code_i));
            end else if ((state_r == DKS_PRESET || state_r == DKS_SCALE)
                         && key_code_i == `DKS_KEY_MINUS) begin
                neg_r <= 1'b1;
            end
        end
    end

    // Offsets and scale factors applied when an entry closes
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            off_x_r <= `DKS_POS_RST;
            off_y_r <= `DKS_POS_RST;
            sc_x_r  <= `DKS_SCALE_ONE;
            sc_y_r  <= `DKS_SCALE_ONE;
        end else if (key_vld_i && !lockout_i && digs_r
                     && state_r != DKS_IDLE && state_nxt == DKS_IDLE) begin
            if (state_r == DKS_PRESET && !tgt_r) begin
                off_x_r <= (neg_r ? -acc_r : acc_r) - pos_x_i;
            end else if (state_r == DKS_PRESET) begin
                off_y_r <= (neg_r ? -acc_r : acc_r) - pos_y_i;
            end else if (state_r == DKS_SCALE && !tgt_r) begin
                sc_x_r  <= neg_r ? -acc_r : acc_r;
            end else if (state_r == DKS_SCALE) begin
                sc_y_r  <= neg_r ? -acc_r : acc_r;
            end
        end
    end

    // Frozen display copy, tracks carriage only when idle
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            frz_x_r <= `DKS_POS_RST;
            frz_y_r <= `DKS_POS_RST;
        end else if (state_r == DKS_IDLE && state_nxt == DKS_IDLE) begin
            frz_x_r <= live_x;
            frz_y_r <= live_y;
        end
    end

    // Record sender
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rec_vld_o <= 1'b0;
            rec_o     <= '0;
        end else begin
            rec_vld_o <= 1'b0;
            if (key_vld_i && !lockout_i) begin
                rec_o.x    <= frz_x_r;
                rec_o.y    <= frz_y_r;
                rec_o.diam <= 1'b0;
                if (state_r == DKS_IDLE || state_r == DKS_DIAM) begin
                    if (key_code_i == `DKS_KEY_AX1) begin
                        rec_vld_o  <= 1'b1;
                        rec_o.kind <= DKS_REC_PENUP;
                        rec_o.diam <= (state_r == DKS_DIAM);
                    end else if (key_code_i == `DKS_KEY_AX2) begin
                        rec_vld_o  <= 1'b1;
                        rec_o.kind <= DKS_REC_PENDOWN;
                        rec_o.diam <= (state_r == DKS_DIAM);
                    end else if (key_code_i == `DKS_KEY_ARCA) begin
                        rec_vld_o  <= 1'b1;
                        rec_o.kind <= DKS_REC_ARCPT;
                        rec_o.diam <= (state_r == DKS_DIAM);
                    end else if (key_code_i == `DKS_KEY_ARCB) begin
                        rec_vld_o  <= 1'b1;
                        rec_o.kind <= DKS_REC_ARCBLK;
                        rec_o.diam <= (state_r == DKS_DIAM);
                        if (state_r == DKS_DIAM) begin
                            rec_o.x <= acc_r;
                        end
                    end
                end else if (state_r == DKS_SHIFTED && key_code_i == `DKS_KEY_MINUS) begin
                    rec_vld_o  <= 1'b1;
                    rec_o.kind <= DKS_REC_EOF;
                end
            end
        end
    end

    // Minus and reset markers for the C+D pattern
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            minus_r    <= 1'b0;
            rst_seen_r <= 1'b1;
        end else if (key_vld_i && !lockout_i) begin
            minus_r    <= (key_code_i == `DKS_KEY_MINUS) && state_r == DKS_IDLE;
            rst_seen_r <= 1'b0;
        end
    end

    // Flash trigger: reset release and shift+P
    logic boot_r;  // First cycle after reset
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            boot_r <= 1'b1;
        end else begin
            boot_r <= 1'b0;
        end
    end

    assign fl_start = boot_r
                      || (key_vld_i && !lockout_i && state_r == DKS_SHIFTED
                          && key_code_i == `DKS_KEY_FNP);
    assign fl_len   = boot_r ? 16'(FLASH_CYC) : 16'(BLINK_CYC);

    always_comb begin
        fl_pat = `DKS_LED_ALL;
        if (!boot_r) begin
            fl_pat = `DKS_LED_OFF;
        end
    end

    dks_led_timer #(
        .CNT_W (16)
    ) u_flash (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .start_i (fl_start),
        .len_i   (fl_len),
        .pat_i   (fl_pat),
        .busy_o  (fl_busy),
        .pat_o   (fl_pat_q)
    );

    // LED pattern
    always_comb begin
        if (lockout_i) begin
            led_o = `DKS_LED_ALL;
        end else if (fl_busy) begin
            led_o = fl_pat_q;
        end else begin
            case (state_r)
                DKS_PRESET:  led_o = `DKS_LED_PRESET;
                DKS_SCALE:   led_o = `DKS_LED_SCALE;
                DKS_SHIFTED: led_o = `DKS_LED_SHIFT;
                DKS_DIAM:    led_o = `DKS_LED_MINUS;
                default:     led_o = (minus_r || rst_seen_r) ? `DKS_LED_MINUS
                                                             : `DKS_LED_IDLE;
            endcase
        end
    end

    // Display and units
    always_comb begin
        case (units_sel_i)
            2'h1:    units_let_o = `DKS_LET_FEET;
            2'h2:    units_let_o = `DKS_LET_METRIC;
            default: units_let_o = `DKS_LET_INCH;
        endcase
    end

    assign disp_top_o = frz_x_r;
    assign disp_bot_o = frz_y_r;
    assign scale_x_o  = sc_x_r;
    assign scale_y_o  = sc_y_r;
    assign frozen_o   = (state_r != DKS_IDLE);

    // Preset entry shows A and D
    property p_preset_led;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state_r == DKS_PRESET && !lockout_i && !fl_busy) |-> led_o == 4'h9;
    endproperty
    a_preset_led: assert property (p_preset_led) else $error("preset leds");

    // Display holds while entry pending
    property p_freeze;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state_r != DKS_IDLE && state_nxt != DKS_IDLE) |=> $stable(disp_top_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("display moved");

    // Shift then minus gives EOF next cycle
    sequence s_shift_minus;
        key_vld_i && !lockout_i && state_r == DKS_SHIFTED && key_code_i == 4'hf;
    endsequence
    property p_eof;
        @(posedge mclk_i) disable iff (!nrst_i)
        s_shift_minus |=> rec_vld_o && rec_o.kind == DKS_REC_EOF;
    endproperty
    a_eof: assert property (p_eof) else $error("no eof");

    // Lockout lights all four
    property p_lock;
        @(posedge mclk_i) disable iff (!nrst_i) lockout_i |-> led_o == 4'hf;
    endproperty
    a_lock: assert property (p_lock) else $error("lockout leds");

endmodule : dks_sequencer

// *** verification/dks_keypad_model.sv ***
// Far-side model: operator keypad strobing key codes and a punch channel taking records.
// Assumes the bench calls press between resets; keys are driven at the falling edge.
`timescale 1ns/10ps

module dks_keypad_model
    import dks_pkg::*;
(
    // Clock
    input  wire logic        mclk_i,
    // Keypad side
    output logic             key_vld_o,
    output logic [3:0]       key_code_o,
    // Punch channel side
    input  wire logic        rec_vld_i,
    input  wire dks_record_t rec_i
);
    int          rec_cnt = 0; // Records punched so far
    dks_record_t last_rec;    // Most recent punched record

    // Idle keypad at time zero
    initial begin
        key_vld_o  = 1'b0;
        key_code_o = 4'h0;
    end

    // One key: a one-cycle strobe with its 4-bit code, then a gap
    task automatic press(input logic [3:0] code);
        @(negedge mclk_i);
        key_vld_o  = 1'b1;
        key_code_o = code;
        @(negedge mclk_i);
        key_vld_o  = 1'b0;
        key_code_o = ~code; // Code is not held outside a strobe
        repeat (3) @(negedge mclk_i);
    endtask : press

    // Punch accepts every record offered, never stalls
    always @(posedge mclk_i) begin
        if (rec_vld_i === 1'b1) begin
            rec_cnt  <= rec_cnt + 1;
            last_rec <= rec_i;
        end
    end
endmodule : dks_keypad_model

// *** verification/dks_sequencer_tb.sv ***
// Self-checking bench for the keypad sequencer: key sequences with expected results.
// Assumes the far-side model in dks_keypad_model and short LED flash counts.
`timescale 1ns/10ps
`include "dks_cfg.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h exp %h", $time, (got), (exp)); end end

module dks_sequencer_tb;
    import dks_pkg::*;

    logic        mclk_i;      // System clock
    logic        nrst_i;      // Reset, active low
    logic        lockout_i;   // Keypad lock
    logic [1:0]  units_sel_i; // Measuring system
    logic [31:0] pos_x_i;     // Carriage X counts
    logic [31:0] pos_y_i;     // Carriage Y counts
    logic        key_vld;     // Key strobe from model
    logic [3:0]  key_code;    // Key code from model
    logic        rec_vld_o;   // Record strobe
    dks_record_t rec_o;       // Record
    logic [31:0] disp_top_o, disp_bot_o, scale_x_o, scale_y_o;
    logic [7:0]  units_let_o; // Units letter
    logic [3:0]  led_o;       // Status dots
    logic        frozen_o;    // Display hold
    int          mismatches = 0;
    int          tests_run  = 0;
    int          n;           // Record count snapshot

    // Plain data keys and the record kinds they produce
    logic [3:0] pkeys [4] = '{`DKS_KEY_AX1, `DKS_KEY_AX2, `DKS_KEY_ARCA, `DKS_KEY_ARCB};
    dks_rec_t   pkind [4] = '{DKS_REC_PENUP, DKS_REC_PENDOWN, DKS_REC_ARCPT, DKS_REC_ARCBLK};
    logic [7:0] lets  [4] = '{`DKS_LET_INCH, `DKS_LET_FEET, `DKS_LET_METRIC, `DKS_LET_INCH};

    // 250 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    dks_sequencer #(.FLASH_CYC(4), .BLINK_CYC(4)) u_dks_sequencer (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .key_vld_i(key_vld), .key_code_i(key_code),
        .lockout_i(lockout_i), .units_sel_i(units_sel_i), .pos_x_i(pos_x_i),
        .pos_y_i(pos_y_i), .rec_vld_o(rec_vld_o), .rec_o(rec_o), .disp_top_o(disp_top_o),
        .disp_bot_o(disp_bot_o), .scale_x_o(scale_x_o), .scale_y_o(scale_y_o),
        .units_let_o(units_let_o), .led_o(led_o), .frozen_o(frozen_o));

    dks_keypad_model u_dks_keypad_model (
        .mclk_i(mclk_i), .key_vld_o(key_vld), .key_code_o(key_code),
        .rec_vld_i(rec_vld_o), .rec_i(rec_o));

    // Counts, verdict, end of run
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    // Bounded wait for an LED pattern; running out is a mismatch
    task automatic wait_led(input logic [3:0] exp);
        tests_run++;
        for (int i = 0; i < 20; i++) begin
            @(negedge mclk_i);
            if (led_o === exp) return;
        end
        mismatches++;
        $display("mismatch at %0t: led %h never reached %h", $time, led_o, exp);
        wrap_up();
    endtask : wait_led

    // Short alias for a key press
    task automatic key(input logic [3:0] c);
        u_dks_keypad_model.press(c);
    endtask : key

    initial begin
        nrst_i = 1'b0;
        lockout_i = 1'b0;
        units_sel_i = 2'h0;
        pos_x_i = 32'h0000_0000;
        pos_y_i = 32'h0000_0000;
        repeat (3) @(negedge mclk_i);
        `CHK(disp_top_o, `DKS_POS_RST)
        `CHK(scale_x_o, `DKS_SCALE_ONE)
        `CHK(scale_y_o, `DKS_SCALE_ONE)
        nrst_i = 1'b1;
        wait_led(`DKS_LED_ALL);
        wait_led(`DKS_LED_MINUS);
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk_i);
            units_sel_i = 2'(i);
            #1 `CHK(units_let_o, lets[i])
        end
        units_sel_i = 2'h0;
        $display("test reset and units done");

        // Plain data keys send the displayed pair with their marker
        pos_x_i = 32'h0000_0005;
        pos_y_i = 32'h0000_0009;
        repeat (3) @(negedge mclk_i);
        `CHK(disp_top_o, 32'h0000_0005)
        `CHK(disp_bot_o, 32'h0000_0009)
        for (int i = 0; i < 4; i++) begin
            n = u_dks_keypad_model.rec_cnt;
            key(pkeys[i]);
            `CHK(u_dks_keypad_model.rec_cnt, n + 1)
            `CHK(u_dks_keypad_model.last_rec.kind, pkind[i])
            `CHK(u_dks_keypad_model.last_rec.x, 32'h0000_0005)
            `CHK(u_dks_keypad_model.last_rec.y, 32'h0000_0009)
        end
        wait_led(`DKS_LED_IDLE);
        $display("test plain keys done");

        // Shifted X preset, display frozen while carriage moves
        key(`DKS_KEY_SHIFT);
        wait_led(`DKS_LED_SHIFT);
        `CHK(frozen_o, 1'b1)
        key(`DKS_KEY_AX1);
        wait_led(`DKS_LED_PRESET);
        pos_x_i = 32'h0000_0050;
        repeat (3) @(negedge mclk_i);
        `CHK(frozen_o, 1'b1)
        `CHK(disp_top_o, 32'h0000_0005)
        key(4'h1);
        key(4'h2);
        key(`DKS_KEY_AX1);
        wait_led(`DKS_LED_IDLE);
        `CHK(frozen_o, 1'b0)
        `CHK(disp_top_o, 32'h0000_000c)
        // Shift Y Y with no digits changes nothing, sends nothing
        n = u_dks_keypad_model.rec_cnt;
        key(`DKS_KEY_SHIFT);
        key(`DKS_KEY_AX2);
        key(`DKS_KEY_AX2);
        wait_led(`DKS_LED_IDLE);
        `CHK(disp_bot_o, 32'h0000_0009)
        `CHK(u_dks_keypad_model.rec_cnt, n)
        // Shifted Y preset
        key(`DKS_KEY_SHIFT);
        key(`DKS_KEY_AX2);
        key(4'h3);
        key(`DKS_KEY_AX2);
        wait_led(`DKS_LED_IDLE);
        `CHK(disp_bot_o, 32'h0000_0003)
        $display("test presets done");

        // Diameter entry, then end of file, then shift plus digit
        key(`DKS_KEY_MINUS);
        wait_led(`DKS_LED_MINUS);
        key(4'h5);
        key(`DKS_KEY_ARCB);
        `CHK(u_dks_keypad_model.last_rec.diam, 1'b1)
        `CHK(u_dks_keypad_model.last_rec.x, 32'h0000_0005)
        n = u_dks_keypad_model.rec_cnt;
        key(`DKS_KEY_SHIFT);
        key(`DKS_KEY_MINUS);
        `CHK(u_dks_keypad_model.rec_cnt, n + 1)
        `CHK(u_dks_keypad_model.last_rec.kind, DKS_REC_EOF)
        key(`DKS_KEY_SHIFT);
        key(4'h4);
        wait_led(`DKS_LED_IDLE);
        `CHK(frozen_o, 1'b0)
        $display("test minus key done");

        // Scale factors, one negative
        key(`DKS_KEY_SHIFT);
        key(`DKS_KEY_ARCA);
        wait_led(`DKS_LED_SCALE);
        key(`DKS_KEY_MINUS);
        key(4'h2);
        key(`DKS_KEY_ARCA);
        wait_led(`DKS_LED_IDLE);
        `CHK(scale_x_o, 32'hffff_fffe)
        key(`DKS_KEY_SHIFT);
        key(`DKS_KEY_ARCB);
        wait_led(`DKS_LED_SCALE);
        key(4'h3);
        key(`DKS_KEY_ARCB);
        wait_led(`DKS_LED_IDLE);
        `CHK(scale_y_o, 32'h0000_0003)
        $display("test scale done");

        // Meaningless key and lockout are ignored
        n = u_dks_keypad_model.rec_cnt;
        key(`DKS_KEY_FNP);
        `CHK(u_dks_keypad_model.rec_cnt, n)
        `CHK(led_o, `DKS_LED_IDLE)
        key(`DKS_KEY_SHIFT);
        key(`DKS_KEY_FNP);
        `CHK(led_o, `DKS_LED_OFF)
        `CHK(u_dks_keypad_model.rec_cnt, n)
        wait_led(`DKS_LED_IDLE);
        lockout_i = 1'b1;
        wait_led(`DKS_LED_ALL);
        key(`DKS_KEY_AX1);
        `CHK(u_dks_keypad_model.rec_cnt, n)
        @(negedge mclk_i);
        lockout_i = 1'b0;
        wait_led(`DKS_LED_IDLE);
        $display("test ignore and lockout done");

        // Reset in mid-run restores defaults and flashes all LEDs
        nrst_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        `CHK(scale_x_o, `DKS_SCALE_ONE)
        `CHK(disp_top_o, `DKS_POS_RST)
        `CHK(rec_vld_o, 1'b0)
        nrst_i = 1'b1;
        wait_led(`DKS_LED_ALL);
        wait_led(`DKS_LED_MINUS);
        $display("test second reset done");
        wrap_up();
    end
endmodule : dks_sequencer_tb
